// ==== verilog/mies_map.svh ====
// named constants for the instruction subset executor
// assumes inclusion by bare name from any design file that needs them
`ifndef MIES_MAP_SVH
`define MIES_MAP_SVH

`define MIES_PC_W          10
`define MIES_PC_LOW_W      9
`define MIES_PC_HIGH_BIT   9
`define MIES_PCHB_JUMP_BIT 1
`define MIES_PC_STEP       10'h001
`define MIES_PC_RESET      10'h000
`define MIES_ADDR_RESET    6'h00
`define MIES_ACC_RESET     8'h00
`define MIES_CARRY_RESET   1'b0
`define MIES_GIE_RESET     1'b0
`define MIES_DEC_STEP      8'h01
`define MIES_ZERO_BYTE     8'h00
`define MIES_DEST_ACC      1'b0
`define MIES_DEST_REG      1'b1
`define MIES_NIBBLE_MAX    4'h9
`define MIES_LOW_FIX       8'h06
`define MIES_HIGH_FIX      8'h60

`endif

// ==== verilog/mies_pkg.sv ====
// types shared by the instruction subset executor
// assumes nothing beyond the core clock domain
package mies_pkg;

    typedef enum logic [2:0] {
        no_op,
        decimal_adjust_op,
        decrement_skip_zero_op,
        interrupt_disable_op,
        interrupt_enable_op,
        direct_jump_op
    } mies_op_e;

    typedef enum logic {
        st_exec,
        st_flush
    } mies_state_e;

endpackage

// ==== verilog/mies_daa.sv ====
// decimal adjust of a binary sum into two packed decimal digits
// assumes carry and half carry come from the addition just before
`timescale 1ns/10ps
`include "mies_map.svh"

module mies_daa
    import mies_pkg::*;
(
    input  wire logic [7:0] sum_in,
    input  wire logic       carry_in,
    input  wire logic       half_carry_in,
    output logic      [7:0] result,
    output logic            carry_out
);

    logic [7:0] fix;
    logic       low_fix;
    logic       high_fix;

    always_comb begin
        low_fix  = half_carry_in || (sum_in[3:0] > `MIES_NIBBLE_MAX);
        // high digit also needs fixing when it is 9 and the low digit is being fixed
        high_fix = carry_in || (sum_in[7:4] > `MIES_NIBBLE_MAX)
                   || ((sum_in[7:4] == `MIES_NIBBLE_MAX) && low_fix);
        fix = `MIES_ZERO_BYTE;
        if (low_fix) begin
            fix = fix | `MIES_LOW_FIX;
        end
        if (high_fix) begin
            fix = fix | `MIES_HIGH_FIX;
        end
        result    = sum_in + fix;
        carry_out = high_fix;
    end

endmodule

// ==== verilog/mies_exec.sv ====
// executor for decimal adjust, decrement-skip, interrupt on/off, direct jump
// assumes register file reads reg_rdata combinationally from op_reg_addr
// and the core supplies the last addition's carry and half carry
`timescale 1ns/10ps
`include "mies_map.svh"

// Overview of operation
// RL1: decimal adjust accumulator, update only carry
// RL2: program puts adjust right after addition
// RL3: program disables interrupts around add and adjust
// RL4: decrement register, result to accumulator or register
// RL5: zero result discards prefetched instruction, runs nop
// RL6: decrement-skip takes one cycle, two on skip
// RL7: interrupt disable clears global interrupt enable
// RL8: direct jump loads nine-bit target into pc
// RL9: direct jump copies high buffer bit 1 to pc
// RL10: interrupt enable sets global interrupt enable
// RL11: adjust, disable one cycle; jump two cycles
module mies_exec
    import mies_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire logic                  op_valid,
    input  wire mies_op_e              op_code,
    input  wire logic [5:0]            op_reg_addr,
    input  wire logic                  op_dest,
    input  wire logic [8:0]            op_target,
    input  wire logic [7:0]            reg_rdata,
    input  wire logic                  add_carry,
    input  wire logic                  add_half_carry,
    input  wire logic [1:0]            program_counter_high_buffer,
    output logic                       op_ready,
    output logic                       discard_fetch,
    output logic      [5:0]            reg_addr,
    output logic      [7:0]            reg_wdata,
    output logic                       reg_we,
    output logic      [7:0]            accumulator,
    output logic                       carry_flag,
    output logic                       global_interrupt_enable,
    output logic      [`MIES_PC_W-1:0] program_counter
);

    mies_state_e           state_r;
    mies_state_e           state_nxt;
    logic                  skip_flush_r;
    logic                  skip_flush_nxt;
    logic [7:0]            acc_r;
    logic [7:0]            acc_nxt;
    logic                  carry_r;
    logic                  carry_nxt;
    logic                  gie_r;
    logic                  gie_nxt;
    logic [`MIES_PC_W-1:0] pc_r;
    logic [`MIES_PC_W-1:0] pc_nxt;
    logic [5:0]            waddr_r;
    logic [5:0]            waddr_nxt;
    logic [7:0]            wdata_r;
    logic [7:0]            wdata_nxt;
    logic                  we_r;
    logic                  we_nxt;
    logic [7:0]            daa_result;
    logic                  daa_carry;
    logic [7:0]            dec_value;
    logic                  take;

    mies_daa u_daa (
        .sum_in        (acc_r),
        .carry_in      (add_carry),
        .half_carry_in (add_half_carry),
        .result        (daa_result),
        .carry_out     (daa_carry)
    );

    assign op_ready                = (state_r == st_exec);
    assign discard_fetch           = (state_r == st_flush);
    assign take                    = op_valid && op_ready;
    assign dec_value               = reg_rdata - `MIES_DEC_STEP;
    assign accumulator             = acc_r;
    assign carry_flag              = carry_r;
    assign global_interrupt_enable = gie_r;
    assign program_counter         = pc_r;
    assign reg_addr                = waddr_r;
    assign reg_wdata               = wdata_r;
    assign reg_we                  = we_r;

    always_comb begin
        state_nxt      = st_exec;
        skip_flush_nxt = 1'b0;
        acc_nxt        = acc_r;
        carry_nxt      = carry_r;
        gie_nxt        = gie_r;
        pc_nxt         = pc_r;
        waddr_nxt      = waddr_r;
        wdata_nxt      = wdata_r;
        we_nxt         = 1'b0;
        if (state_r == st_flush) begin
            // a skipped slot still advances past the discarded instruction
            if (skip_flush_r) begin
                pc_nxt = pc_r + `MIES_PC_STEP; // RL5
            end
        end else if (take) begin
            pc_nxt = pc_r + `MIES_PC_STEP;
            unique case (op_code)
                no_op: begin
                end
                decimal_adjust_op: begin
                    acc_nxt   = daa_result; // RL1
                    carry_nxt = daa_carry; // RL1
                end
                decrement_skip_zero_op: begin
                    if (op_dest == `MIES_DEST_ACC) begin
                        acc_nxt = dec_value; // RL4
                    end else begin
                        waddr_nxt = op_reg_addr; // RL4
                        wdata_nxt = dec_value; // RL4
                        we_nxt    = 1'b1; // RL4
                    end
                    if (dec_value == `MIES_ZERO_BYTE) begin
                        state_nxt      = st_flush; // RL6
                        skip_flush_nxt = 1'b1; // RL5
                    end
                end
                interrupt_disable_op: begin
                    gie_nxt = 1'b0; // RL7
                end
                interrupt_enable_op: begin
                    gie_nxt = 1'b1; // RL10
                end
                direct_jump_op: begin
                    pc_nxt = {program_counter_high_buffer[`MIES_PCHB_JUMP_BIT], // RL9
                              op_target}; // RL8
                    state_nxt = st_flush; // RL11
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r      <= st_exec;
            skip_flush_r <= 1'b0;
            acc_r        <= `MIES_ACC_RESET;
            carry_r      <= `MIES_CARRY_RESET;
            gie_r        <= `MIES_GIE_RESET;
            pc_r         <= `MIES_PC_RESET;
            waddr_r      <= `MIES_ADDR_RESET;
            wdata_r      <= `MIES_ZERO_BYTE;
            we_r         <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            skip_flush_r <= skip_flush_nxt;
            acc_r        <= acc_nxt;
            carry_r      <= carry_nxt;
            gie_r        <= gie_nxt;
            pc_r         <= pc_nxt;
            waddr_r      <= waddr_nxt;
            wdata_r      <= wdata_nxt;
            we_r         <= we_nxt;
        end
    end

    sequence s_dec_zero;
        take && (op_code == decrement_skip_zero_op) && (reg_rdata == `MIES_DEC_STEP);
    endsequence

    sequence s_flush_then_ready;
        discard_fetch && !op_ready ##1 op_ready && !discard_fetch;
    endsequence

    a_daa_carry_only: assert property (@(posedge clock) disable iff (!rst_b) // RL1
        take && (op_code == decimal_adjust_op)
        |=> (acc_r == $past(daa_result)) && (carry_r == $past(daa_carry))
            && (gie_r == $past(gie_r)) && !reg_we)
        else $error("decimal adjust result or flags wrong");

    a_dec_to_acc: assert property (@(posedge clock) disable iff (!rst_b) // RL4
        take && (op_code == decrement_skip_zero_op) && (op_dest == `MIES_DEST_ACC)
        |=> (acc_r == $past(reg_rdata) - `MIES_DEC_STEP) && !reg_we)
        else $error("decrement to accumulator wrong");

    a_dec_to_reg: assert property (@(posedge clock) disable iff (!rst_b) // RL4
        take && (op_code == decrement_skip_zero_op) && (op_dest == `MIES_DEST_REG)
        |=> reg_we && (reg_wdata == $past(reg_rdata) - `MIES_DEC_STEP)
            && (reg_addr == $past(op_reg_addr)) && (acc_r == $past(acc_r)))
        else $error("decrement to register wrong");

    a_skip_discards: assert property (@(posedge clock) disable iff (!rst_b) // RL5
        s_dec_zero |=> s_flush_then_ready)
        else $error("zero decrement did not discard the next instruction");

    a_noskip_single: assert property (@(posedge clock) disable iff (!rst_b) // RL6
        take && (op_code == decrement_skip_zero_op) && (reg_rdata != `MIES_DEC_STEP)
        |=> op_ready && !discard_fetch)
        else $error("non zero decrement stalled");

    a_skip_pc_two: assert property (@(posedge clock) disable iff (!rst_b) // RL6
        s_dec_zero |-> ##2 (pc_r == $past(pc_r, 2) + `MIES_PC_STEP + `MIES_PC_STEP))
        else $error("skip did not advance pc by two");

    a_int_disable: assert property (@(posedge clock) disable iff (!rst_b) // RL7
        take && (op_code == interrupt_disable_op) |=> !gie_r && op_ready)
        else $error("interrupt disable failed");

    a_int_enable: assert property (@(posedge clock) disable iff (!rst_b) // RL10
        take && (op_code == interrupt_enable_op) |=> gie_r)
        else $error("interrupt enable failed");

    a_jump_target: assert property (@(posedge clock) disable iff (!rst_b) // RL8
        take && (op_code == direct_jump_op)
        |=> (pc_r[`MIES_PC_LOW_W-1:0] == $past(op_target))
            ##1 (pc_r == $past(pc_r)))
        else $error("direct jump target wrong");

    a_jump_high_bit: assert property (@(posedge clock) disable iff (!rst_b) // RL9
        take && (op_code == direct_jump_op)
        |=> pc_r[`MIES_PC_HIGH_BIT]
            == $past(program_counter_high_buffer[`MIES_PCHB_JUMP_BIT]))
        else $error("direct jump high bit wrong");

    a_jump_two_cycle: assert property (@(posedge clock) disable iff (!rst_b) // RL11
        take && (op_code == direct_jump_op) |=> s_flush_then_ready)
        else $error("direct jump not two cycles");

    a_daa_one_cycle: assert property (@(posedge clock) disable iff (!rst_b) // RL11
        take && (op_code == decimal_adjust_op) |=> op_ready && !discard_fetch)
        else $error("decimal adjust not single cycle");

endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the instruction subset executor
// assumes the bench plays the fetch stage and register file at the ports
`timescale 1ns/10ps

module tb_top
    import mies_pkg::*;
;
    logic       clock, rst_b, op_valid, op_dest, reg_we, carry_flag;
    logic       add_carry, add_half_carry, op_ready, discard_fetch;
    logic       global_interrupt_enable;
    mies_op_e   op_code;
    logic [5:0] op_reg_addr, reg_addr;
    logic [8:0] op_target;
    logic [7:0] reg_rdata, reg_wdata, accumulator;
    logic [1:0] program_counter_high_buffer;
    logic [9:0] program_counter, exp_pc;
    int         n_mismatch = 0;
    int         checked    = 0;

    mies_exec u_mies_exec (.clock(clock), .rst_b(rst_b), .op_valid(op_valid),
        .op_code(op_code), .op_reg_addr(op_reg_addr), .op_dest(op_dest),
        .op_target(op_target), .reg_rdata(reg_rdata), .add_carry(add_carry),
        .add_half_carry(add_half_carry),
        .program_counter_high_buffer(program_counter_high_buffer),
        .op_ready(op_ready), .discard_fetch(discard_fetch), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .accumulator(accumulator),
        .carry_flag(carry_flag), .global_interrupt_enable(global_interrupt_enable),
        .program_counter(program_counter));

    always #2 clock = ~clock;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // leaves op_valid high so the caller may offer the next op back to back
    task automatic issue(input mies_op_e c, input logic [5:0] a, input logic d,
                         input logic [8:0] t, input logic [7:0] rd);
        chk("op_ready", op_ready, 10'h001);
        op_valid = 1'b1;
        op_code = c;
        op_reg_addr = a;
        op_dest = d;
        op_target = t;
        reg_rdata = rd;
        @(posedge clock);
        #1;
    endtask

    task automatic idle();
        op_valid = 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic t_dec(input logic [7:0] rd, input logic d, input logic [5:0] a);
        logic [7:0] res;
        res = rd - 8'h01;
        issue(decrement_skip_zero_op, a, d, 9'h000, rd);
        exp_pc = exp_pc + 10'h001;
        chk("reg_we", reg_we, d);
        if (d) begin
            chk("reg_wdata", reg_wdata, res);
            chk("reg_addr", reg_addr, a);
        end else begin
            chk("accumulator", accumulator, res);
        end
        chk("discard_fetch", discard_fetch, res == 8'h00);
        chk("op_ready", op_ready, res != 8'h00);
        chk("program_counter", program_counter, exp_pc);
        if (res == 8'h00) begin
            // refused slot: drop the offer while the flush runs
            op_valid = 1'b0;
            @(posedge clock);
            #1;
            exp_pc = exp_pc + 10'h001;
            chk("program_counter", program_counter, exp_pc);
            chk("op_ready", op_ready, 10'h001);
            chk("discard_fetch", discard_fetch, 10'h000);
            chk("reg_we", reg_we, 10'h000);
        end
    endtask

    task automatic t_daa(input logic [7:0] ld, input logic c, input logic h,
                         input logic [7:0] ex, input logic exc);
        // interrupts stay off from the sum to its adjust
        issue(interrupt_disable_op, 6'h00, 1'b0, 9'h000, 8'h00);
        exp_pc = exp_pc + 10'h001;
        chk("gie", global_interrupt_enable, 10'h000);
        // the decrement stands in for the addition that leaves the sum in the accumulator
        t_dec(ld + 8'h01, 1'b0, 6'h05);
        add_carry = c;
        add_half_carry = h;
        issue(decimal_adjust_op, 6'h00, 1'b0, 9'h000, 8'h00);
        exp_pc = exp_pc + 10'h001;
        chk("accumulator", accumulator, ex);
        chk("carry_flag", carry_flag, exc);
        chk("reg_we", reg_we, 10'h000);
        chk("discard_fetch", discard_fetch, 10'h000);
        chk("program_counter", program_counter, exp_pc);
        issue(interrupt_enable_op, 6'h00, 1'b0, 9'h000, 8'h00);
        exp_pc = exp_pc + 10'h001;
        chk("gie", global_interrupt_enable, 10'h001);
        chk("accumulator", accumulator, ex);
        chk("program_counter", program_counter, exp_pc);
        idle();
    endtask

    // entered with interrupts enabled; no_op must leave the flag alone
    task automatic t_gie();
        mies_op_e seq[4]   = '{no_op, interrupt_disable_op, no_op, interrupt_enable_op};
        logic     exp_g[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        foreach (seq[i]) begin
            issue(seq[i], 6'h00, 1'b0, 9'h000, 8'h00);
            exp_pc = exp_pc + 10'h001;
            chk("gie", global_interrupt_enable, exp_g[i]);
            chk("program_counter", program_counter, exp_pc);
        end
        idle();
    endtask

    task automatic t_jump(input logic [1:0] hb, input logic [8:0] tg);
        program_counter_high_buffer = hb;
        issue(direct_jump_op, 6'h00, 1'b0, tg, 8'h00);
        op_valid = 1'b0;
        exp_pc = {hb[1], tg};
        chk("program_counter", program_counter, exp_pc);
        chk("discard_fetch", discard_fetch, 10'h001);
        chk("op_ready", op_ready, 10'h000);
        @(posedge clock);
        #1;
        chk("program_counter", program_counter, exp_pc);
        chk("op_ready", op_ready, 10'h001);
    endtask

    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        op_valid = 1'b0;
        op_code = no_op;
        op_reg_addr = 6'h00;
        op_dest = 1'b0;
        op_target = 9'h000;
        reg_rdata = 8'h00;
        add_carry = 1'b0;
        add_half_carry = 1'b0;
        program_counter_high_buffer = 2'h0;
        exp_pc = 10'h000;
        repeat (4) @(posedge clock);
        #1;
        rst_b = 1'b1;
        chk("accumulator", accumulator, 10'h000);
        chk("gie", global_interrupt_enable, 10'h000);
        chk("program_counter", program_counter, 10'h000);
        chk("discard_fetch", discard_fetch, 10'h000);
        t_dec(8'h01, 1'b1, 6'h3f);
        t_dec(8'h01, 1'b0, 6'h00);
        t_dec(8'h00, 1'b1, 6'h2a);
        t_dec(8'h80, 1'b0, 6'h11);
        idle();
        t_daa(8'h4d, 1'b0, 1'b0, 8'h53, 1'b0);
        t_daa(8'h9a, 1'b0, 1'b0, 8'h00, 1'b1);
        t_daa(8'h41, 1'b0, 1'b1, 8'h47, 1'b0);
        t_daa(8'h12, 1'b1, 1'b0, 8'h72, 1'b1);
        t_daa(8'h99, 1'b0, 1'b0, 8'h99, 1'b0);
        t_gie();
        t_jump(2'b10, 9'h1a5);
        t_jump(2'b01, 9'h1fe);
        t_jump(2'b11, 9'h000);
        end_sim();
    end

    // whole run needs well under 200 cycles
    initial begin
        #8000;
        n_mismatch++;
        end_sim();
    end
endmodule
